// ==== common/sync_pkg.sv ====
/*
 * Shared constants and types for the SYSREF masking and trigger sync block.
 * Assumes a single core clock; register addresses are 12-bit serial-port offsets.
 */
package sync_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_MASK_CTRL = 12'hd4d;
  localparam logic [11:0] ADDR_DELAY_SET = 12'he20;
  localparam logic [11:0] ADDR_DELAY_ACT = 12'he21;
  localparam logic [11:0] ADDR_MODE_CTRL = 12'he24;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int MASK_START_BIT = 6;
  localparam int MASK_EN_BIT = 5;
  localparam int MASK_CNT_LSB = 1;
  localparam int MASK_CNT_MSB = 4;
  localparam int KILL_BIT = 0;
  localparam int OSC_RESET_EN_BIT = 4;
  localparam int STEP_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Timing counts: decimation divide in core clock cycles, reset period in decimation cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] DEC_DIV = 4'h4;
  localparam logic [7:0] OSC_RESET_PERIOD = 8'h10;

  typedef enum logic [1:0] {
    MODE_SYSREF = 2'b00,
    MODE_TRIG = 2'b01,
    MODE_SYSREF_TRIG = 2'b10,
    MODE_DIRECT = 2'b11
  } sync_mode_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_ARMED = 3'b001,
    M_PASS = 3'b010,
    M_MASK = 3'b011,
    M_TAIL = 3'b100
  } mask_state_t;
endpackage

// ==== common/mask_if.sv ====
/*
 * Carrier between the control block and the SYSREF masking unit.
 * Assumes both ends run on the same core clock.
 */
interface mask_if;
  logic en;
  logic start;
  logic [3:0] count;
  logic sysref;
  logic done;
  logic block;

  modport ctrl (output en, output start, output count, output sysref, input done, input block);
  modport unit (input en, input start, input count, input sysref, output done, output block);
endinterface

// ==== rtl/sysref_mask_unit.sv ====
/*
 * SYSREF masking unit: passes one rising edge after start, then blocks count+1 edges.
 * Assumes sysref is synchronous to core_clk; the master enable acts as a clock enable.
 */
module sysref_mask_unit
  import sync_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  mask_if.unit mi
);
  import sync_pkg::*;

  typedef struct packed {
    mask_state_t st;
    logic [3:0] left;
    logic prev;
  } unit_state_t;

  unit_state_t s;
  unit_state_t next_s;
  logic rise;

  assign rise = mi.sysref & ~s.prev;
  // Block the masked edges and the tail of the last one, never the passed edge
  assign mi.block = mi.en & ((s.st == M_MASK) | (s.st == M_TAIL));
  assign mi.done = mi.en & (s.st == M_TAIL) & ~mi.sysref;

  always_comb begin
    next_s = s;
    // Disabled unit holds every flop, standing in for the gated clock
    if (mi.en) begin
      next_s.prev = mi.sysref;
      case (s.st)
        M_IDLE: begin
          if (mi.start) begin
            next_s.st = M_ARMED;
          end
        end
        M_ARMED: begin
          if (!mi.start) begin
            next_s.st = M_IDLE;
          end else if (rise) begin
            next_s.st = M_PASS;
          end
        end
        M_PASS: begin
          if (!mi.start) begin
            next_s.st = M_IDLE;
          end else if (!mi.sysref) begin
            next_s.st = M_MASK;
            next_s.left = mi.count;
          end
        end
        M_MASK: begin
          if (!mi.start) begin
            next_s.st = M_IDLE;
          end else if (rise) begin
            if (s.left == 4'h0) begin
              next_s.st = M_TAIL;
            end else begin
              next_s.left = s.left - 4'h1;
            end
          end
        end
        M_TAIL: begin
          if (!mi.sysref) begin
            next_s.st = M_IDLE;
          end
        end
        default: begin
          next_s.st = M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  a_first_edge_pass: assert property (@(posedge core_clk) disable iff (rst)
    (mi.en && mi.start && s.st == M_ARMED && rise) |=> (s.st == M_PASS && !mi.block))
    else $error("first sysref edge after start was not passed");

  a_done_to_idle: assert property (@(posedge core_clk) disable iff (rst)
    mi.done |=> (s.st == M_IDLE && !mi.block))
    else $error("masking did not end after done");

  a_gate_hold: assert property (@(posedge core_clk) disable iff (rst)
    !mi.en |=> $stable(s))
    else $error("mask unit state moved while disabled");

  a_count_load: assert property (@(posedge core_clk) disable iff (rst)
    (mi.en && mi.start && s.st == M_PASS && !mi.sysref) |=> (s.left == $past(mi.count) && s.st == M_MASK))
    else $error("mask count not loaded after passed edge");
endmodule

// ==== rtl/sysref_mask_trigger_sync.sv ====
/*
 * SYSREF conditioning and periodic trigger sync control, with its register file.
 * Assumes sysref_in and trig_in are synchronous to core_clk and registers are
 * written and read through a simple address/strobe port from the serial port.
 */
// Operation
// - After start, pass first edge, mask rest
// - Start bit self-clears when masking ends
// - Masking works only while enable set
// - Mask count field holds edges minus one
// - Kill bit blocks SYSREF immediately
// - Delay trigger by programmed decimation cycles
// - Report hardware delay in read-only register
// - Periodic oscillator resets follow trigger when enabled
// - Auto-increment delay after each issued trigger
// - Control fields and delay reset to zero
// - Two-bit mode selects synchronisation source
module sysref_mask_trigger_sync
  import sync_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sysref_in,
  input wire logic trig_in,
  output logic sysref_out,
  output logic trig_out,
  output logic osc_reset
);
  import sync_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic mask_start;
    logic mask_en;
    logic [3:0] mask_cnt;
    logic kill;
    logic [7:0] delay_set;
    logic [7:0] delay_act;
    logic osc_periodic_reset_en;
    logic delay_step_after_trig;
    sync_mode_t mode;
    logic [7:0] rdata;
    logic sysref_out;
    logic trig_out;
    logic osc_reset;
    logic [3:0] div;
    logic trig_prev;
    logic pending;
    logic [7:0] dcnt;
    logic osc_run;
    logic [7:0] per_cnt;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  mask_if mi ();
  logic dec_en;
  logic gated_sysref;
  logic trig_src;
  logic trig_rise;
  logic fire;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] target);
    hit = (addr == target);
  endfunction

  sysref_mask_unit u_mask (
    .core_clk(core_clk),
    .rst(rst),
    .mi(mi)
  );

  assign mi.en = s.mask_en;
  assign mi.start = s.mask_start;
  assign mi.count = s.mask_cnt;
  assign mi.sysref = sysref_in;

  assign reg_rdata = s.rdata;
  assign sysref_out = s.sysref_out;
  assign trig_out = s.trig_out;
  assign osc_reset = s.osc_reset;

  // ---------------------------------------------------------------
  // Datapath helpers
  // ---------------------------------------------------------------
  assign dec_en = (s.div == DEC_DIV - 4'h1);
  assign gated_sysref = sysref_in & ~mi.block & ~s.kill;

  always_comb begin
    // Source selection by sync mode
    case (s.mode)
      MODE_SYSREF: trig_src = gated_sysref;
      MODE_TRIG: trig_src = trig_in;
      MODE_SYSREF_TRIG: trig_src = sysref_in;
      default: trig_src = trig_in;
    endcase
  end

  assign trig_rise = trig_src & ~s.trig_prev;
  assign fire = (trig_rise && s.mode == MODE_DIRECT) || (s.pending && dec_en && s.dcnt == 8'h00);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.trig_out = 1'b0;
    next_s.osc_reset = 1'b0;
    next_s.rdata = 8'h00;
    next_s.div = dec_en ? 4'h0 : s.div + 4'h1;
    next_s.trig_prev = trig_src;

    // Hardware clear goes first so a same-cycle software set wins
    if (mi.done) begin
      next_s.mask_start = 1'b0;
    end

    // Trigger delay in decimation cycles, common to every mode except MODE_DIRECT
    if (trig_rise && s.mode != MODE_DIRECT) begin
      next_s.pending = 1'b1;
      next_s.dcnt = s.delay_set;
      next_s.delay_act = s.delay_set;
    end else if (s.pending && dec_en) begin
      if (s.dcnt == 8'h00) begin
        next_s.pending = 1'b0;
      end else begin
        next_s.dcnt = s.dcnt - 8'h01;
      end
    end

    if (fire) begin
      next_s.trig_out = 1'b1;
      if (s.delay_step_after_trig) begin
        next_s.delay_set = s.delay_set + 8'h01;
      end
    end

    // Periodic oscillator reset, started by an issued trigger
    if (fire && s.osc_periodic_reset_en) begin
      next_s.osc_run = 1'b1;
      next_s.per_cnt = 8'h00;
      next_s.osc_reset = 1'b1;
    end else if (s.osc_run && dec_en) begin
      if (s.per_cnt == OSC_RESET_PERIOD - 8'h01) begin
        next_s.per_cnt = 8'h00;
        next_s.osc_reset = 1'b1;
      end else begin
        next_s.per_cnt = s.per_cnt + 8'h01;
      end
    end

    // Register writes
    if (reg_wr) begin
      if (hit(reg_addr, ADDR_MASK_CTRL)) begin
        next_s.mask_start = reg_wdata[MASK_START_BIT];
        next_s.mask_en = reg_wdata[MASK_EN_BIT];
        next_s.mask_cnt = reg_wdata[MASK_CNT_MSB:MASK_CNT_LSB];
        next_s.kill = reg_wdata[KILL_BIT];
      end else if (hit(reg_addr, ADDR_DELAY_SET)) begin
        next_s.delay_set = reg_wdata;
      end else if (hit(reg_addr, ADDR_MODE_CTRL)) begin
        next_s.osc_periodic_reset_en = reg_wdata[OSC_RESET_EN_BIT];
        next_s.delay_step_after_trig = reg_wdata[STEP_BIT];
        next_s.mode = sync_mode_t'(reg_wdata[MODE_MSB:MODE_LSB]);
      end
    end

    // Disabling stops the periodic resets at once
    if (!next_s.osc_periodic_reset_en) begin
      next_s.osc_run = 1'b0;
      next_s.osc_reset = 1'b0;
    end

    // Kill takes effect on the very edge that writes it
    next_s.sysref_out = sysref_in & ~mi.block & ~next_s.kill;

    // Register reads; unmapped offsets read zero
    if (reg_rd) begin
      if (hit(reg_addr, ADDR_MASK_CTRL)) begin
        next_s.rdata = {1'b0, s.mask_start, s.mask_en, s.mask_cnt, s.kill};
      end else if (hit(reg_addr, ADDR_DELAY_SET)) begin
        next_s.rdata = s.delay_set;
      end else if (hit(reg_addr, ADDR_DELAY_ACT)) begin
        next_s.rdata = s.delay_act;
      end else if (hit(reg_addr, ADDR_MODE_CTRL)) begin
        next_s.rdata = {3'b000, s.osc_periodic_reset_en, 1'b0, s.delay_step_after_trig, s.mode};
      end
    end
  end

  // All control fields come up at zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_kill_blocks: assert property (@(posedge core_clk) disable iff (rst)
    s.kill |-> !sysref_out)
    else $error("sysref passed while kill set");

  a_delay_expire: assert property (@(posedge core_clk) disable iff (rst)
    (s.pending && dec_en && s.dcnt == 8'h00)
      |=> (trig_out && s.pending == $past(trig_rise && s.mode != MODE_DIRECT)))
    else $error("delayed trigger not issued at count end");

  a_actual_latch: assert property (@(posedge core_clk) disable iff (rst)
    (trig_rise && s.mode != MODE_DIRECT) |=> s.delay_act == $past(s.delay_set))
    else $error("reported delay does not match programmed delay");

  a_osc_follows: assert property (@(posedge core_clk) disable iff (rst)
    osc_reset |-> s.osc_periodic_reset_en)
    else $error("oscillator reset while disabled");

  a_step_delay: assert property (@(posedge core_clk) disable iff (rst)
    (fire && s.delay_step_after_trig && !(reg_wr && hit(reg_addr, ADDR_DELAY_SET)))
      |=> s.delay_set == $past(s.delay_set) + 8'h01)
    else $error("trigger delay not stepped after trigger");

  a_direct_now: assert property (@(posedge core_clk) disable iff (rst)
    (trig_rise && s.mode == MODE_DIRECT) |=> trig_out)
    else $error("direct pulse mode trigger delayed");

  a_start_clear: assert property (@(posedge core_clk) disable iff (rst)
    (mi.done && !reg_wr) |=> !s.mask_start)
    else $error("start bit did not self clear");
endmodule

// ==== tb/sync_source.sv ====
/*
 * Model of the clock source that drives SYSREF and trigger pulses.
 * Assumes the bench core clock; both lines are synchronous to it and idle low.
 */
module sync_source (
  input wire logic core_clk,
  output logic sysref_in,
  output logic trig_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sysref_in = 1'b0;
    trig_in = 1'b0;
  end

  // ---------------------------------------------------------------
  // One pulse on the trigger line when trig is set, else on SYSREF
  // ---------------------------------------------------------------
  task automatic pulse(input bit trig, input int hi, input int lo);
    @(posedge core_clk);
    if (trig) trig_in <= 1'b1;
    else sysref_in <= 1'b1;
    repeat (hi) @(posedge core_clk);
    trig_in <= 1'b0;
    sysref_in <= 1'b0;
    repeat (lo) @(posedge core_clk);
  endtask
endmodule

// ==== tb/sysref_mask_trigger_sync_test.sv ====
/*
 * Self-checking bench for the SYSREF masking and trigger sync block.
 * Assumes sync_pkg and the sync_source model; registers reached by addr/strobe.
 */
module sysref_mask_trigger_sync_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sync_pkg::*;

  logic core_clk, rst, reg_wr, reg_rd, sysref_in, trig_in, sysref_out, trig_out, osc_reset;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic prev_sys = 1'b0;
  int mismatches = 0, n_tests = 0, n_sys = 0, n_osc = 0, lat;

  sysref_mask_trigger_sync i_sysref_mask_trigger_sync (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sysref_in(sysref_in),
    .trig_in(trig_in), .sysref_out(sysref_out), .trig_out(trig_out), .osc_reset(osc_reset));
  sync_source i_sync_source (.core_clk(core_clk), .sysref_in(sysref_in), .trig_in(trig_in));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Counts passed SYSREF pulses and oscillator resets
  always @(posedge core_clk) begin
    if (sysref_out === 1'b1 && prev_sys !== 1'b1) n_sys++;
    if (osc_reset === 1'b1) n_osc++;
    prev_sys <= sysref_out;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(what, exp, reg_rdata);
  endtask

  // Latency counted from the edge that launches the source pulse
  task automatic fire(input bit trig, input int lo, input int hi);
    lat = 0;
    fork
      i_sync_source.pulse(trig, 2, 2);
      for (int i = 1; i <= 600 && lat == 0; i++) begin
        @(posedge core_clk);
        if (trig_out === 1'b1) lat = i;
      end
    join
    if (lat == 0) begin
      mismatches++;
      results();
    end
    chk("trigger latency", 8'(lo), (lat >= lo && lat <= hi) ? 8'(lo) : 8'(lat));
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic mask_test();
    int base;
    base = n_sys;
    wr(ADDR_MASK_CTRL, 8'h62);
    repeat (3) i_sync_source.pulse(1'b0, 3, 4);
    chk("edges passed while masking", 8'h01, 8'(n_sys - base));
    rd(ADDR_MASK_CTRL, 8'h22, "start after masking");
    i_sync_source.pulse(1'b0, 3, 4);
    chk("edge after masking", 8'h02, 8'(n_sys - base));
    wr(ADDR_MASK_CTRL, 8'h40);
    repeat (2) i_sync_source.pulse(1'b0, 3, 4);
    chk("edges with unit off", 8'h04, 8'(n_sys - base));
    wr(ADDR_MASK_CTRL, 8'h01);
    i_sync_source.pulse(1'b0, 3, 4);
    chk("edges with kill set", 8'h04, 8'(n_sys - base));
    wr(ADDR_MASK_CTRL, 8'h00);
    $display("done: masking and kill");
  endtask

  task automatic delay_test();
    int base;
    wr(ADDR_MODE_CTRL, 8'h15);
    wr(ADDR_DELAY_SET, 8'h03);
    base = n_osc;
    fire(1'b1, 16, 19);
    rd(ADDR_DELAY_ACT, 8'h03, "actual delay");
    rd(ADDR_DELAY_SET, 8'h04, "stepped delay");
    repeat (66) @(posedge core_clk);
    chk("periodic resets", 8'h02, 8'(n_osc - base));
    wr(ADDR_MODE_CTRL, 8'h01);
    base = n_osc;
    fire(1'b1, 20, 23);
    repeat (70) @(posedge core_clk);
    chk("resets when disabled", 8'h00, 8'(n_osc - base));
    $display("done: trigger delay");
  endtask

  task automatic mode_test();
    wr(ADDR_DELAY_SET, 8'h00);
    for (int m = 0; m < 4; m++) begin
      // Kill blocks only the conditioned source, so mode 10 must still fire
      if (m == 2) wr(ADDR_MASK_CTRL, 8'h01);
      wr(ADDR_MODE_CTRL, 8'(m));
      fire(m[0], (m == 3) ? 3 : 4, (m == 3) ? 3 : 7);
    end
    wr(ADDR_MASK_CTRL, 8'h00);
    $display("done: sync modes");
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADDR_MASK_CTRL, REG_RESET, "mask ctrl reset");
    rd(ADDR_DELAY_SET, REG_RESET, "delay set reset");
    rd(ADDR_DELAY_ACT, REG_RESET, "delay actual reset");
    rd(12'hd4e, 8'h00, "unmapped read");
    $display("done: reset values");
    mask_test();
    delay_test();
    mode_test();
    results();
  end
endmodule
